//--- common/seq_cfg_pkg.sv
package seq_cfg_pkg;
  // --------------------------------------------------------------------------
  // register indices
  // --------------------------------------------------------------------------
  localparam logic [7:0] IDX_AUX_RANGE = 8'h19;
  localparam logic [7:0] IDX_LEGACY_BANK = 8'h11;
  localparam logic [7:0] IDX_FIFO_THRESH = 8'h20;
  localparam logic [7:0] IDX_MODE_SEL = 8'h21;
  localparam logic [7:0] IDX_FEATURE = 8'h22;
  localparam logic [7:0] IDX_READ_BANK = 8'h23;
  localparam logic [7:0] IDX_WRITE_BANK = 8'h24;
  localparam logic [7:0] IDX_SHARED_BANK = 8'h25;
  localparam logic [7:0] IDX_ROW_TIMING = 8'h26;
  localparam logic [7:0] IDX_COL_TIMING = 8'h27;
  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_AUX_RANGE = 8'h01;
  localparam logic [7:0] RST_FIFO_THRESH = 8'h81;
  localparam logic [7:0] RST_ROW_TIMING = 8'h01;
  localparam logic [7:0] RST_COL_TIMING = 8'h10;
  // --------------------------------------------------------------------------
  // writable bit masks
  // --------------------------------------------------------------------------
  localparam logic [7:0] MSK_AUX_RANGE = 8'h3F;
  localparam logic [7:0] MSK_FIFO_THRESH = 8'hCF;
  localparam logic [7:0] MSK_MODE_SEL = 8'hF7;
  localparam logic [7:0] MSK_FEATURE = 8'h7C;
  localparam logic [7:0] MSK_BANK = 8'h7F;
  localparam logic [7:0] MSK_ROW_TIMING = 8'h0B;
  localparam logic [7:0] MSK_COL_TIMING = 8'h36;
  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int AUX_DAC_BIT = 4;
  localparam int AUX_EN_BIT = 5;
  localparam int MODE_DBL_BIT = 0;
  localparam int MODE_TRI_BIT = 1;
  localparam int MODE_PACKED_BIT = 2;
  localparam int MODE_CHARACTER_CLOCK_BIT = 4;
  localparam int MODE_SYNC_BIT = 7;
  localparam int FEAT_CMDBUF_BIT = 2;
  localparam int FEAT_WCACHE_BIT = 3;
  localparam int FEAT_LATCH_BIT = 4;
  localparam int FEAT_WM4_BIT = 5;
  localparam int FEAT_RM4_BIT = 6;
  localparam int ROW_HALF_BIT = 3;
  localparam int COL_HALF_BIT = 1;
  localparam int COL_PULSE_BIT = 2;
  // --------------------------------------------------------------------------
  // decode ranges (DAC_STD_LO/HI are full io addresses, DAC_EXT and AUX LO/HI offsets within the 2xNN page, IO_PAGE_HI its top nibble)
  // --------------------------------------------------------------------------
  localparam logic [15:0] DAC_STD_LO = 16'h03C6;
  localparam logic [15:0] DAC_STD_HI = 16'h03C9;
  localparam logic [7:0] DAC_EXT_LO = 8'h80;
  localparam logic [7:0] DAC_EXT_HI = 8'h9F;
  localparam logic [7:0] AUX_LO = 8'hA0;
  localparam logic [7:0] AUX_HI = 8'hBF;
  localparam logic [3:0] IO_PAGE_HI = 4'h2;
  localparam logic [3:0] CMD_MMIO_LIMIT = 4'h7;
  localparam logic [7:0] COPROC_LAST = 8'h7F;
  // --------------------------------------------------------------------------
  // timing counts and enumerations
  // --------------------------------------------------------------------------
  localparam logic [3:0] TEXT_BURST_BASE = 4'h6;
  localparam logic [2:0] ROW_PRE_BASE = 3'h2;
  localparam logic [1:0] SHIFT_FOLLOW = 2'h0;
  localparam logic [2:0] SHIFT_ATTR3 = 3'h3;
  localparam logic [3:0] ATTR_MODE_3 = 4'h3;
  typedef enum logic [1:0] {HTIME_X1, HTIME_X2, HTIME_X3} htime_t;
  typedef struct packed {
    logic [3:0] text_burst;
    logic [3:0] gfx_fifo_level;
    htime_t htime;
    logic packed_pixel;
    logic character_clock_half;
    logic [2:0] shift_load_vclks;
    logic sync_clocking;
    logic cmd_fifo_en;
    logic write_cache_en;
    logic latch_64;
    logic write_mode_4;
    logic read_mode_4;
    logic [2:0] row_precharge;
    logic row_half;
    logic col_half;
    logic [1:0] col_pulse;
  } timing_cfg_t;
endpackage

//--- logic/ext_sequencer_config_regs.sv
`timescale 1ns/1ps
module ext_sequencer_config_regs
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // indexed register port
  input wire logic [7:0] reg_index,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // host io decode
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic vl_bus,
  output logic dac_select,
  output logic aux_chip_select_n,
  output logic aux_read_strobe_n,
  output logic aux_write_strobe_n,
  // host memory window
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic mmio_wr,
  input wire logic [7:0] mmio_offset,
  input wire logic block_transfer,
  input wire logic [3:0] attr_mode,
  input wire logic [2:0] gfx_write_mode,
  output logic [6:0] host_address_hi,
  output logic to_cmd_fifo,
  output logic [2:0] eff_write_mode,
  output logic direct_read,
  // timing configuration
  output seq_cfg_pkg::timing_cfg_t cfg
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [7:0] aux_range_decode;
  logic [7:0] refresh_fifo_threshold;
  logic [7:0] timing_mode_select;
  logic [7:0] feature_select;
  logic [6:0] read_bank_extended;
  logic [6:0] write_bank_extended;
  logic [7:0] row_strobe_timing;
  logic [7:0] column_strobe_timing;
  logic [7:0] next_rdata;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aux_range_decode <= seq_cfg_pkg::RST_AUX_RANGE;
      refresh_fifo_threshold <= seq_cfg_pkg::RST_FIFO_THRESH;
      timing_mode_select <= 8'h00;
      feature_select <= 8'h00;
      row_strobe_timing <= seq_cfg_pkg::RST_ROW_TIMING;
      column_strobe_timing <= seq_cfg_pkg::RST_COL_TIMING;
    end
    else if (reg_wr)
    begin
      unique case (reg_index)
        seq_cfg_pkg::IDX_AUX_RANGE:
          aux_range_decode <= reg_wdata & seq_cfg_pkg::MSK_AUX_RANGE;
        seq_cfg_pkg::IDX_FIFO_THRESH:
          refresh_fifo_threshold <= reg_wdata & seq_cfg_pkg::MSK_FIFO_THRESH;
        // host sequences the update inside software reset
        seq_cfg_pkg::IDX_MODE_SEL:
          timing_mode_select <= reg_wdata & seq_cfg_pkg::MSK_MODE_SEL;
        seq_cfg_pkg::IDX_FEATURE:
          feature_select <= reg_wdata & seq_cfg_pkg::MSK_FEATURE;
        seq_cfg_pkg::IDX_ROW_TIMING:
          row_strobe_timing <= reg_wdata & seq_cfg_pkg::MSK_ROW_TIMING;
        seq_cfg_pkg::IDX_COL_TIMING:
          column_strobe_timing <= reg_wdata & seq_cfg_pkg::MSK_COL_TIMING;
        default:
        begin
        end
      endcase
    end
  end

  // bank registers: legacy nibbles and the shared port alias these
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      read_bank_extended <= 7'h00;
      write_bank_extended <= 7'h00;
    end
    else if (reg_wr)
    begin
      unique case (reg_index)
        seq_cfg_pkg::IDX_LEGACY_BANK:
        begin
          read_bank_extended[3:0] <= reg_wdata[3:0];
          write_bank_extended[3:0] <= reg_wdata[7:4];
        end
        seq_cfg_pkg::IDX_READ_BANK:
          read_bank_extended <= reg_wdata[6:0];
        seq_cfg_pkg::IDX_WRITE_BANK:
          write_bank_extended <= reg_wdata[6:0];
        seq_cfg_pkg::IDX_SHARED_BANK:
        begin
          read_bank_extended <= reg_wdata[6:0];
          write_bank_extended <= reg_wdata[6:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // read back
  // --------------------------------------------------------------------------
  always_comb
  begin
    unique case (reg_index)
      seq_cfg_pkg::IDX_AUX_RANGE: next_rdata = aux_range_decode;
      seq_cfg_pkg::IDX_LEGACY_BANK:
        next_rdata = {write_bank_extended[3:0], read_bank_extended[3:0]};
      seq_cfg_pkg::IDX_FIFO_THRESH: next_rdata = refresh_fifo_threshold;
      seq_cfg_pkg::IDX_MODE_SEL: next_rdata = timing_mode_select;
      seq_cfg_pkg::IDX_FEATURE: next_rdata = feature_select;
      seq_cfg_pkg::IDX_READ_BANK: next_rdata = {1'b0, read_bank_extended};
      seq_cfg_pkg::IDX_WRITE_BANK: next_rdata = {1'b0, write_bank_extended};
      seq_cfg_pkg::IDX_SHARED_BANK: next_rdata = {1'b0, write_bank_extended};
      seq_cfg_pkg::IDX_ROW_TIMING: next_rdata = row_strobe_timing;
      seq_cfg_pkg::IDX_COL_TIMING: next_rdata = column_strobe_timing;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // --------------------------------------------------------------------------
  // io decode
  // --------------------------------------------------------------------------
  logic page_hit;
  logic dac_std;
  logic dac_ext;
  logic aux_hit;

  assign page_hit = io_addr[15:12] == seq_cfg_pkg::IO_PAGE_HI
    && io_addr[11:8] == aux_range_decode[3:0];
  assign dac_std = io_addr >= seq_cfg_pkg::DAC_STD_LO && io_addr <= seq_cfg_pkg::DAC_STD_HI;
  assign dac_ext = page_hit && io_addr[7:0] >= seq_cfg_pkg::DAC_EXT_LO
    && io_addr[7:0] <= seq_cfg_pkg::DAC_EXT_HI;
  assign aux_hit = aux_range_decode[seq_cfg_pkg::AUX_EN_BIT] && page_hit
    && io_addr[7:0] >= seq_cfg_pkg::AUX_LO && io_addr[7:0] <= seq_cfg_pkg::AUX_HI;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dac_select <= 1'b0;
      aux_chip_select_n <= 1'b1;
      aux_read_strobe_n <= 1'b1;
      aux_write_strobe_n <= 1'b1;
    end
    else
    begin
      dac_select <= (io_rd || io_wr)
        && (dac_std || (aux_range_decode[seq_cfg_pkg::AUX_DAC_BIT] && dac_ext));
      aux_chip_select_n <= !(vl_bus && aux_hit && (io_rd || io_wr));
      aux_read_strobe_n <= !(!vl_bus && aux_hit && io_rd);
      aux_write_strobe_n <= !(!vl_bus && aux_hit && io_wr);
    end
  end

  // --------------------------------------------------------------------------
  // host memory path
  // --------------------------------------------------------------------------
  logic packed_mode;
  assign packed_mode = timing_mode_select[seq_cfg_pkg::MODE_PACKED_BIT];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      host_address_hi <= 7'h00;
      to_cmd_fifo <= 1'b0;
      eff_write_mode <= 3'h0;
      direct_read <= 1'b0;
    end
    else
    begin
      if (mem_wr)
        host_address_hi <= write_bank_extended;
      else if (mem_rd)
        host_address_hi <= read_bank_extended;
      to_cmd_fifo <= feature_select[seq_cfg_pkg::FEAT_CMDBUF_BIT]
        && ((mmio_wr && mmio_offset <= seq_cfg_pkg::COPROC_LAST)
        || (mem_wr && block_transfer));
      eff_write_mode <= (packed_mode && feature_select[seq_cfg_pkg::FEAT_WM4_BIT])
        ? 3'h4 : gfx_write_mode;
      direct_read <= packed_mode && feature_select[seq_cfg_pkg::FEAT_RM4_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // timing configuration
  // --------------------------------------------------------------------------
  seq_cfg_pkg::timing_cfg_t next_cfg;
  logic [1:0] shift_code;

  always_comb
  begin
    shift_code = timing_mode_select[6:5];
    next_cfg.text_burst = seq_cfg_pkg::TEXT_BURST_BASE
      + {1'b0, refresh_fifo_threshold[7:6], 1'b0};
    next_cfg.gfx_fifo_level = refresh_fifo_threshold[3:0];
    if (timing_mode_select[seq_cfg_pkg::MODE_TRI_BIT])
      next_cfg.htime = seq_cfg_pkg::HTIME_X3;
    else if (timing_mode_select[seq_cfg_pkg::MODE_DBL_BIT])
      next_cfg.htime = seq_cfg_pkg::HTIME_X2;
    else
      next_cfg.htime = seq_cfg_pkg::HTIME_X1;
    next_cfg.packed_pixel = packed_mode;
    next_cfg.character_clock_half = timing_mode_select[seq_cfg_pkg::MODE_CHARACTER_CLOCK_BIT];
    // zero means follow the clocking mode register
    if (shift_code == seq_cfg_pkg::SHIFT_FOLLOW)
      next_cfg.shift_load_vclks = 3'h0;
    else if (shift_code == 2'h3 && attr_mode == seq_cfg_pkg::ATTR_MODE_3)
      next_cfg.shift_load_vclks = seq_cfg_pkg::SHIFT_ATTR3;
    else
      next_cfg.shift_load_vclks = {shift_code, 1'b0};
    next_cfg.sync_clocking = timing_mode_select[seq_cfg_pkg::MODE_SYNC_BIT];
    next_cfg.cmd_fifo_en = feature_select[seq_cfg_pkg::FEAT_CMDBUF_BIT];
    next_cfg.write_cache_en = feature_select[seq_cfg_pkg::FEAT_WCACHE_BIT];
    next_cfg.latch_64 = feature_select[seq_cfg_pkg::FEAT_LATCH_BIT];
    next_cfg.write_mode_4 = packed_mode && feature_select[seq_cfg_pkg::FEAT_WM4_BIT];
    next_cfg.read_mode_4 = packed_mode && feature_select[seq_cfg_pkg::FEAT_RM4_BIT];
    next_cfg.row_precharge = seq_cfg_pkg::ROW_PRE_BASE
      + {1'b0, row_strobe_timing[1:0]};
    next_cfg.row_half = row_strobe_timing[seq_cfg_pkg::ROW_HALF_BIT];
    next_cfg.col_half = column_strobe_timing[seq_cfg_pkg::COL_HALF_BIT];
    next_cfg.col_pulse = column_strobe_timing[seq_cfg_pkg::COL_PULSE_BIT]
      ? 2'h2 : 2'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cfg <= '0;
    else
      cfg <= next_cfg;
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // read bank write followed at once by a host read
  sequence s_read_bank_write;
    reg_wr && reg_index == seq_cfg_pkg::IDX_READ_BANK;
  endsequence
  sequence s_host_read;
    mem_rd && !mem_wr;
  endsequence

  a_shared_bank_write: assert property (
    reg_wr && reg_index == seq_cfg_pkg::IDX_SHARED_BANK
    |=> read_bank_extended == $past(reg_wdata[6:0])
    && write_bank_extended == read_bank_extended)
    else $error("shared bank write did not load both banks");
  a_legacy_mirror: assert property (
    reg_rd && reg_index == seq_cfg_pkg::IDX_LEGACY_BANK
    |=> reg_rdata == {$past(write_bank_extended[3:0]), $past(read_bank_extended[3:0])})
    else $error("legacy bank read does not mirror banks");
  a_legacy_write: assert property (
    reg_wr && reg_index == seq_cfg_pkg::IDX_LEGACY_BANK
    |=> read_bank_extended[3:0] == $past(reg_wdata[3:0])
    && write_bank_extended[3:0] == $past(reg_wdata[7:4]))
    else $error("legacy bank write did not reach both banks");
  a_read_bank_load: assert property (
    s_read_bank_write ##1 s_host_read |=> host_address_hi == $past(reg_wdata[6:0], 2))
    else $error("read bank not used for host read");
  a_write_bank_use: assert property (
    mem_wr |=> host_address_hi == $past(write_bank_extended))
    else $error("write bank not used for host write");
  a_dac_ext_off: assert property (
    !aux_range_decode[seq_cfg_pkg::AUX_DAC_BIT] && !dac_std
    |=> !dac_select)
    else $error("extended dac decoded while disabled");
  a_aux_gate: assert property (
    !aux_range_decode[seq_cfg_pkg::AUX_EN_BIT]
    |=> aux_chip_select_n && aux_read_strobe_n && aux_write_strobe_n)
    else $error("aux strobe while aux decode disabled");
  a_text_burst: assert property (
    1'b1 |=> cfg.text_burst
    == 4'(6 + 2 * $past(refresh_fifo_threshold[7:6])))
    else $error("text burst length wrong");
  a_gfx_level: assert property (
    1'b1 |=> cfg.gfx_fifo_level == $past(refresh_fifo_threshold[3:0]))
    else $error("graphics refill level not following register");
  a_htime_triple: assert property (
    timing_mode_select[seq_cfg_pkg::MODE_TRI_BIT] |=> cfg.htime == seq_cfg_pkg::HTIME_X3)
    else $error("horizontal timing not tripled");
  a_shift_follow: assert property (
    shift_code == seq_cfg_pkg::SHIFT_FOLLOW |=> cfg.shift_load_vclks == 3'h0)
    else $error("shift/load not following clocking mode");
  a_sync_clock: assert property (
    1'b1 |=> cfg.sync_clocking == $past(timing_mode_select[seq_cfg_pkg::MODE_SYNC_BIT]))
    else $error("clocking select not following mode bit 7");
  a_cmd_fifo_gate: assert property (
    !feature_select[seq_cfg_pkg::FEAT_CMDBUF_BIT]
    |=> !to_cmd_fifo)
    else $error("command fifo routed while disabled");
  a_shift_attr3: assert property (
    shift_code == 2'h3 && attr_mode == seq_cfg_pkg::ATTR_MODE_3
    |=> cfg.shift_load_vclks == 3'h3)
    else $error("attribute mode 3 shift/load not every three clocks");
  a_row_precharge: assert property (
    1'b1 |=> cfg.row_precharge
    == 3'(2 + $past(row_strobe_timing[1:0])))
    else $error("row precharge count wrong");
  a_col_pulse: assert property (
    1'b1 |=> cfg.col_pulse
    == ($past(column_strobe_timing[seq_cfg_pkg::COL_PULSE_BIT]) ? 2'h2 : 2'h1))
    else $error("column pulse width wrong");
  a_write_mode4: assert property (
    packed_mode && feature_select[seq_cfg_pkg::FEAT_WM4_BIT]
    |=> eff_write_mode == 3'h4)
    else $error("write mode 4 not applied");
  a_read_mode4: assert property (
    packed_mode && feature_select[seq_cfg_pkg::FEAT_RM4_BIT] |=> direct_read)
    else $error("read mode 4 not applied");
  a_latch_width: assert property (
    1'b1 |=> cfg.latch_64
    == $past(feature_select[seq_cfg_pkg::FEAT_LATCH_BIT]))
    else $error("latch width not following feature bit");
  a_reserved_zero: assert property (
    (timing_mode_select & ~seq_cfg_pkg::MSK_MODE_SEL) == 8'h00
    && (column_strobe_timing & ~seq_cfg_pkg::MSK_COL_TIMING) == 8'h00)
    else $error("reserved bits stored");

endmodule

//--- verif/ext_sequencer_config_regs_tb.sv
`timescale 1ns/1ps
module ext_sequencer_config_regs_tb;
  logic clk, rstn, io_rd, io_wr, vl_bus, mem_rd, mem_wr, mmio_wr, block_transfer;
  logic reg_wr, reg_rd, dac_select, aux_chip_select_n, aux_read_strobe_n;
  logic aux_write_strobe_n, to_cmd_fifo, direct_read, rw, inpg, dac_e, auxh;
  logic [15:0] io_addr;
  logic [7:0] mmio_offset, reg_index, reg_wdata, reg_rdata, d, v, f20, f21, f22, f26, f27;
  logic [7:0] rb, wb;
  logic [3:0] attr_mode, pg;
  logic [2:0] gfx_write_mode, eff_write_mode;
  logic [6:0] host_address_hi;
  seq_cfg_pkg::timing_cfg_t cfg;
  int num_errors, n_tests;
  localparam logic [7:0] IDX [10] = '{8'h11, 8'h19, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
    8'h25, 8'h26, 8'h27};
  localparam logic [7:0] RST [10] = '{8'h00, seq_cfg_pkg::RST_AUX_RANGE,
    seq_cfg_pkg::RST_FIFO_THRESH, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    seq_cfg_pkg::RST_ROW_TIMING, seq_cfg_pkg::RST_COL_TIMING};
  localparam logic [7:0] MSK [10] = '{8'hFF, seq_cfg_pkg::MSK_AUX_RANGE,
    seq_cfg_pkg::MSK_FIFO_THRESH, seq_cfg_pkg::MSK_MODE_SEL, seq_cfg_pkg::MSK_FEATURE,
    8'h7F, 8'h7F, 8'h7F, seq_cfg_pkg::MSK_ROW_TIMING, seq_cfg_pkg::MSK_COL_TIMING};
  localparam logic [7:0] LO [6] = '{8'h80, 8'h9F, 8'hA0, 8'hBF, 8'h7F, 8'hC0};

  ext_sequencer_config_regs i_ext_sequencer_config_regs (.clk(clk), .rstn(rstn),
    .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .vl_bus(vl_bus), .dac_select(dac_select), .aux_chip_select_n(aux_chip_select_n),
    .aux_read_strobe_n(aux_read_strobe_n), .aux_write_strobe_n(aux_write_strobe_n),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mmio_wr(mmio_wr), .mmio_offset(mmio_offset),
    .block_transfer(block_transfer), .attr_mode(attr_mode),
    .gfx_write_mode(gfx_write_mode), .host_address_hi(host_address_hi),
    .to_cmd_fifo(to_cmd_fifo), .eff_write_mode(eff_write_mode),
    .direct_read(direct_read), .cfg(cfg));
  host_cpu_model i_host_cpu_model (.clk(clk), .reg_index(reg_index), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  always #20 clk = ~clk;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic mem(input logic r, input logic w);
    @(posedge clk);
    #1;
    mem_rd = r;
    mem_wr = w;
    settle();
  endtask
  function automatic logic [31:0] exp_cfg(input logic [7:0] a0, a1, a2, a6, a7,
    input logic [3:0] am);
    seq_cfg_pkg::timing_cfg_t c;
    c = '0;
    c.text_burst = 4'h6 + {1'b0, a0[7:6], 1'b0};
    c.gfx_fifo_level = a0[3:0];
    c.htime = a1[1] ? seq_cfg_pkg::HTIME_X3 : (a1[0] ? seq_cfg_pkg::HTIME_X2
      : seq_cfg_pkg::HTIME_X1);
    c.packed_pixel = a1[2];
    c.character_clock_half = a1[4];
    c.shift_load_vclks = (a1[6:5] == 2'h3 && am == 4'h3) ? 3'h3 : {a1[6:5], 1'b0};
    c.sync_clocking = a1[7];
    c.cmd_fifo_en = a2[2];
    c.write_cache_en = a2[3];
    c.latch_64 = a2[4];
    c.write_mode_4 = a2[5] && a1[2];
    c.read_mode_4 = a2[6] && a1[2];
    c.row_precharge = 3'h2 + {1'b0, a6[1:0]};
    c.row_half = a6[3];
    c.col_half = a7[1];
    c.col_pulse = a7[2] ? 2'h2 : 2'h1;
    return 32'(c);
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #2000000;
    num_errors++;
    wrap_up();
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    {clk, rstn, io_rd, io_wr, vl_bus, mem_rd, mem_wr, mmio_wr, block_transfer} = '0;
    {io_addr, mmio_offset, attr_mode, gfx_write_mode} = '0;
    num_errors = 0;
    n_tests = 0;
    d = 8'($urandom(32'h0AB6));
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      i_host_cpu_model.rd(IDX[i], d);
      check("reset value", d, RST[i]);
    end
    for (int i = 0; i < 10; i++)
    begin
      if (IDX[i] == seq_cfg_pkg::IDX_MODE_SEL)
        i_host_cpu_model.wr_mode(8'hFF);
      else
        i_host_cpu_model.wr(IDX[i], 8'hFF);
      i_host_cpu_model.rd(IDX[i], d);
      check("writable bits", d, MSK[i]);
    end
    i_host_cpu_model.wr(8'h30, 8'hFF);
    i_host_cpu_model.rd(8'h30, d);
    check("unmapped index", d, 8'h00);
    repeat (16)
    begin
      rb = 8'($urandom) & 8'h7F;
      wb = 8'($urandom) & 8'h7F;
      // host read stands across the bank writes
      mem_rd = 1'b1;
      i_host_cpu_model.wr(seq_cfg_pkg::IDX_READ_BANK, rb);
      i_host_cpu_model.wr(seq_cfg_pkg::IDX_WRITE_BANK, wb);
      i_host_cpu_model.rd(seq_cfg_pkg::IDX_LEGACY_BANK, d);
      check("legacy bank", d, {wb[3:0], rb[3:0]});
      mem(1'b1, 1'b0);
      check("read address", host_address_hi, rb[6:0]);
      mem(1'b1, 1'b1);
      check("write address", host_address_hi, wb[6:0]);
      mem(1'b0, 1'b0);
      check("held address", host_address_hi, wb[6:0]);
      v = 8'($urandom);
      i_host_cpu_model.wr(seq_cfg_pkg::IDX_LEGACY_BANK, v);
      i_host_cpu_model.rd(seq_cfg_pkg::IDX_READ_BANK, d);
      check("read bank alias", d & 8'h0F, v & 8'h0F);
      i_host_cpu_model.rd(seq_cfg_pkg::IDX_WRITE_BANK, d);
      check("write bank alias", d & 8'h0F, v >> 4);
      v = 8'($urandom);
      i_host_cpu_model.wr(seq_cfg_pkg::IDX_SHARED_BANK, v);
      for (int k = 5; k < 8; k++)
      begin
        i_host_cpu_model.rd(IDX[k], d);
        check("shared bank", d, v & 8'h7F);
      end
    end
    repeat (40)
    begin
      f20 = 8'($urandom) & seq_cfg_pkg::MSK_FIFO_THRESH;
      f21 = 8'($urandom);
      f21[0] = f21[0] & ~f21[1];
      f22 = 8'($urandom) & seq_cfg_pkg::MSK_FEATURE;
      f26 = 8'($urandom) & seq_cfg_pkg::MSK_ROW_TIMING;
      f27 = 8'($urandom) & seq_cfg_pkg::MSK_COL_TIMING;
      i_host_cpu_model.wr(seq_cfg_pkg::IDX_FIFO_THRESH, f20);
      i_host_cpu_model.wr_mode(f21);
      f21 = f21 & seq_cfg_pkg::MSK_MODE_SEL;
      i_host_cpu_model.wr(seq_cfg_pkg::IDX_FEATURE, f22);
      i_host_cpu_model.wr(seq_cfg_pkg::IDX_ROW_TIMING, f26);
      i_host_cpu_model.wr(seq_cfg_pkg::IDX_COL_TIMING, f27);
      @(posedge clk);
      #1;
      attr_mode = ($urandom % 2) ? 4'h3 : 4'($urandom);
      gfx_write_mode = 3'($urandom);
      {mmio_wr, block_transfer, mem_wr, mem_rd} = {3'($urandom), 1'b1};
      mmio_offset = ($urandom % 2) ? 8'h7F + 8'($urandom % 2) : 8'($urandom);
      settle();
      check("cfg", 32'(cfg), exp_cfg(f20, f21, f22, f26, f27, attr_mode));
      check("write mode", eff_write_mode, (f22[5] && f21[2]) ? 3'h4 : gfx_write_mode);
      check("direct read", direct_read, f22[6] && f21[2]);
      check("cmd fifo", to_cmd_fifo, f22[2] && ((mmio_wr && mmio_offset <= 8'h7F)
        || (mem_wr && block_transfer)));
    end
    repeat (64)
    begin
      pg = 4'($urandom);
      d = (8'($urandom) & 8'h30) | {4'h0, pg};
      i_host_cpu_model.wr(8'h19, d);
      @(posedge clk);
      #1;
      io_addr = ($urandom % 4 == 0) ? 16'h03C5 + 16'($urandom % 6)
        : {4'h2, pg + 4'(($urandom % 4) == 0), LO[$urandom % 6]};
      vl_bus = 1'($urandom);
      rw = 1'($urandom);
      io_rd = rw;
      io_wr = ~rw;
      settle();
      inpg = io_addr[15:12] == 4'h2 && io_addr[11:8] == pg;
      dac_e = (io_addr >= 16'h03C6 && io_addr <= 16'h03C9)
        || (d[4] && inpg && io_addr[7:0] >= 8'h80 && io_addr[7:0] <= 8'h9F);
      auxh = d[5] && inpg && io_addr[7:0] >= 8'hA0 && io_addr[7:0] <= 8'hBF;
      check("dac select", dac_select, dac_e);
      check("aux chip select", aux_chip_select_n, !(auxh && vl_bus));
      check("aux read strobe", aux_read_strobe_n, !(auxh && !vl_bus && rw));
      check("aux write strobe", aux_write_strobe_n, !(auxh && !vl_bus && !rw));
    end
    wrap_up();
  end
endmodule

//--- verif/host_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// host side of the indexed register port
// ----------------------------------------------------------------------------
module host_cpu_model
(
  // clock
  input wire logic clk,
  // indexed register port
  output logic [7:0] reg_index,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  logic sw_reset;
  initial
  begin
    reg_index = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    sw_reset = 1'b0;
  end
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_index = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // released lines show the inverse, never the last value
    reg_index = ~idx;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_index = idx;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_index = ~idx;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
  // mode select is only changed while the sequencer is held in software reset
  task automatic wr_mode(input logic [7:0] d);
    sw_reset = 1'b1;
    wr(seq_cfg_pkg::IDX_MODE_SEL, d & seq_cfg_pkg::MSK_MODE_SEL);
    sw_reset = 1'b0;
  endtask
endmodule
